/* qmu_cfg.svh */
// Offsets, field positions, reset values and limits of the frame status and transmit command block
`ifndef QMU_CFG_SVH
`define QMU_CFG_SVH

// Register indexes; the byte address is four times the index
`define IDX_RX_HEAD_STATUS   10'h07c
`define IDX_RX_HEAD_LENGTH   10'h07e
`define IDX_TX_QUEUE_COMMAND 10'h080
`define IDX_TX_SPACE_REQUEST 10'h09e
`define IDX_RX_RELEASE       10'h0c0
`define IDX_RX_FRAME_COUNT   10'h0c2

// Head status word fields
`define HS_VALID  15
`define HS_TCP    11
`define HS_UDP    10
`define HS_BCAST  7
`define HS_MCAST  6
`define HS_UCAST  5
`define HS_SYMBOL 4
`define HS_TYPE   3
`define HS_LONG   2
`define HS_RUNT   1
`define HS_CRC    0

// Transmit queue command fields
`define TQ_MANUAL 0
`define TQ_WATCH  1
`define TQ_AUTO   2

// Reset values
`define TQ_CMD_RESET    3'h0
`define TX_SPACE_RESET  16'h0000

// Limits: 1500 for the length/type field, 2000 bytes for a frame
`define TYPE_LIMIT 16'h05dc
`define LONG_LIMIT 12'h7d0

// Receive status queue geometry
`define RXQ_DEPTH 16
`define RXQ_AW    4
`define ENTRY_W   24

// Cycles before a new head entry is readable
`define HEAD_SETTLE 2'h2

// Bus responses
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

/* qmu_pkg.sv */
// Types shared by the frame status and transmit command block
package qmu_pkg;
	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_HEAD_STATUS,
		SEL_HEAD_LENGTH,
		SEL_TX_COMMAND,
		SEL_TX_SPACE,
		SEL_RX_RELEASE,
		SEL_RX_COUNT
	} reg_sel_t;

	typedef enum logic [1:0] {
		W_IDLE = 2'b01,
		W_RESP = 2'b10
	} wr_state_t;

	typedef enum logic [1:0] {
		R_IDLE = 2'b01,
		R_DATA = 2'b10
	} rd_state_t;
endpackage

/* rx_frame_status_tx_queue_cmd.sv */
// Receive head frame status queue, transmit queue command and AXI4-Lite registers
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "qmu_cfg.svh"
// How it works
// - Status bit 11 set when head frame has bad TCP checksum.
// - Status bit 10 set when head frame has bad UDP checksum.
// - Status bit 7 set for a broadcast destination.
// - Status bit 6 set for multicast, broadcast included.
// - Status bit 5 set for a unicast destination.
// - Status bit 4 set when a symbol error hit the frame.
// - Status bit 3 set when length/type exceeds 1500.
// - Bit 3 meaningless for runts; it reads zero then.
// - Bit 2 marks frames over 2000 bytes; kept only with pass-bad.
// - Oversize flag never truncates the stored frame.
// - Bit 1 marks runts; kept only with pass-bad.
// - Bit 0 marks CRC failures; kept only with pass-bad.
// - Length word bits 11-0 give head frame bytes; 15-12 zero.
// - Status and length stay readable for the head frame until a release write.
// - A command write setting bit 0 while bit 0 reads clear queues the prepared transmit frame.
// - While bit 2 set, prepared frames queue automatically.
// - Bit 1 arms space watch; event when requested space free.
// - Bit 1 self clears after the frame is sent.
// - Bit 0 queues one frame and self clears when sent.
// - Status bit 15 set only while a complete head frame is valid.
module rx_frame_status_tx_queue_cmd (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// AXI4-Lite write address and data
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// AXI4-Lite write response
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// AXI4-Lite read
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Receive engine, one pulse per finished frame
	input  wire logic        rx_frame_done,
	input  wire logic [47:0] rx_dest_addr,
	input  wire logic [15:0] rx_length_type,
	input  wire logic [11:0] rx_byte_count,
	input  wire logic        rx_tcp_bad,
	input  wire logic        rx_udp_bad,
	input  wire logic        rx_symbol_error,
	input  wire logic        rx_runt,
	input  wire logic        rx_crc_error,
	input  wire logic        pass_bad_frame,
	output logic      [4:0]  rx_frame_counter,
	// Transmit engine
	input  wire logic        tx_frame_prepared,
	input  wire logic        tx_frame_sent,
	input  wire logic [12:0] tx_free_bytes,
	output logic             tx_enqueue,
	output logic             tx_space_event
);
	import qmu_pkg::*;

	wr_state_t wr_state;
	rd_state_t rd_state;

	logic [11:0] aw_addr_q;
	logic        aw_have;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_have;
	logic        wr_fire;
	reg_sel_t    wr_sel;

	logic [15:0] tx_space_request;
	logic [2:0]  tx_queue_command;
	logic        cmd_write;

	logic [`RXQ_AW-1:0]  wr_ptr;
	logic [`RXQ_AW-1:0]  rd_ptr;
	logic [`RXQ_AW:0]    count;
	logic [1:0]          settle;
	logic [`ENTRY_W-1:0] head_entry;
	logic [`ENTRY_W-1:0] new_entry;
	logic [11:0]         new_status;
	logic                frame_bad;
	logic                push;
	logic                pop;
	logic                head_frame_valid;
	logic [15:0]         rx_head_status;
	logic [15:0]         rx_head_length;

	// Register select from a byte address
	function automatic reg_sel_t decode(input logic [11:0] addr);
		reg_sel_t sel;
		sel = SEL_NONE;
		unique case (addr[11:2])
			`IDX_RX_HEAD_STATUS: begin
				sel = SEL_HEAD_STATUS;
			end
			`IDX_RX_HEAD_LENGTH: begin
				sel = SEL_HEAD_LENGTH;
			end
			`IDX_TX_QUEUE_COMMAND: begin
				sel = SEL_TX_COMMAND;
			end
			`IDX_TX_SPACE_REQUEST: begin
				sel = SEL_TX_SPACE;
			end
			`IDX_RX_RELEASE: begin
				sel = SEL_RX_RELEASE;
			end
			`IDX_RX_FRAME_COUNT: begin
				sel = SEL_RX_COUNT;
			end
			default: begin
				sel = SEL_NONE;
			end
		endcase
		return sel;
	endfunction

	// Byte lane merge of a 16-bit register
	function automatic logic [15:0] merge16(
		input logic [15:0] old,
		input logic [31:0] data,
		input logic [3:0]  strb
	);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// Write channel
	assign awready = (wr_state == W_IDLE) && !aw_have;
	assign wready  = (wr_state == W_IDLE) && !w_have;
	assign bvalid  = (wr_state == W_RESP);
	assign wr_fire = (wr_state == W_IDLE) && aw_have && w_have;
	assign wr_sel  = decode(aw_addr_q);

	always_ff @(posedge clk) begin
		if (reset) begin
			aw_have   <= 1'b0;
			aw_addr_q <= 12'h000;
		end else if (awvalid && awready) begin
			aw_have   <= 1'b1;
			aw_addr_q <= awaddr;
		end else if (wr_fire) begin
			aw_have <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			w_have   <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else if (wvalid && wready) begin
			w_have   <= 1'b1;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end else if (wr_fire) begin
			w_have <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_state <= W_IDLE;
			bresp    <= `RESP_OKAY;
		end else begin
			unique case (wr_state)
				W_IDLE: begin
					if (wr_fire) begin
						wr_state <= W_RESP;
						bresp    <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
					end
				end
				W_RESP: begin
					if (bready) begin
						wr_state <= W_IDLE;
					end
				end
			endcase
		end
	end

	// Software writable registers
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_space_request <= `TX_SPACE_RESET;
		end else if (wr_fire && wr_sel == SEL_TX_SPACE) begin
			tx_space_request <= merge16(tx_space_request, w_data_q, w_strb_q);
		end
	end

	// command write reaches the queue logic
	assign cmd_write = wr_fire && (wr_sel == SEL_TX_COMMAND) && w_strb_q[0];

	tx_queue_ctrl u_tx_queue_ctrl (
		.clk            (clk),
		.reset          (reset),
		.cmd_write      (cmd_write),
		.cmd_data       (w_data_q[2:0]),
		.cmd_state      (tx_queue_command),
		.frame_prepared (tx_frame_prepared),
		.frame_sent     (tx_frame_sent),
		.free_bytes     (tx_free_bytes),
		.space_request  (tx_space_request),
		.enqueue        (tx_enqueue),
		.space_event    (tx_space_event)
	);

	// Read channel
	assign arready = (rd_state == R_IDLE);
	assign rvalid  = (rd_state == R_DATA);

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_state <= R_IDLE;
			rdata    <= 32'h0000_0000;
			rresp    <= `RESP_OKAY;
		end else begin
			unique case (rd_state)
				R_IDLE: begin
					if (arvalid) begin
						rd_state <= R_DATA;
						rresp    <= `RESP_OKAY;
						unique case (decode(araddr))
							SEL_HEAD_STATUS: begin
								rdata <= {16'h0000, rx_head_status};
							end
							SEL_HEAD_LENGTH: begin
								rdata <= {16'h0000, rx_head_length};
							end
							SEL_TX_COMMAND: begin
								rdata <= {29'h0, tx_queue_command};
							end
							SEL_TX_SPACE: begin
								rdata <= {16'h0000, tx_space_request};
							end
							SEL_RX_RELEASE: begin
								rdata <= 32'h0000_0000;
							end
							SEL_RX_COUNT: begin
								rdata <= {27'h0, count};
							end
							SEL_NONE: begin
								rdata <= 32'h0000_0000;
								rresp <= `RESP_SLVERR;
							end
						endcase
					end
				end
				R_DATA: begin
					if (rready) begin
						rd_state <= R_IDLE;
					end
				end
			endcase
		end
	end

	// Status of a finishing frame
	always_comb begin
		new_status = 12'h000;
		new_status[`HS_TCP] = rx_tcp_bad;
		new_status[`HS_UDP] = rx_udp_bad;
		new_status[`HS_BCAST] = &rx_dest_addr;
		new_status[`HS_MCAST] = rx_dest_addr[40];
		new_status[`HS_UCAST] = !rx_dest_addr[40];
		new_status[`HS_SYMBOL] = rx_symbol_error;
		new_status[`HS_TYPE] = (rx_length_type > `TYPE_LIMIT) && !rx_runt;
		new_status[`HS_LONG] = rx_byte_count > `LONG_LIMIT;
		new_status[`HS_RUNT] = rx_runt;
		new_status[`HS_CRC] = rx_crc_error;
	end

	// full byte count kept whatever the flag
	assign new_entry = {new_status, rx_byte_count};
	assign frame_bad = new_status[`HS_LONG] || rx_runt || rx_crc_error;

	assign push = rx_frame_done && (!frame_bad || pass_bad_frame)
		&& (count != 5'(`RXQ_DEPTH));

	assign pop = wr_fire && (wr_sel == SEL_RX_RELEASE) && w_strb_q[0]
		&& w_data_q[0] && head_frame_valid;

	rx_status_mem u_rx_status_mem (
		.clk     (clk),
		.reset   (reset),
		.wr_en   (push),
		.wr_addr (wr_ptr),
		.wr_data (new_entry),
		.rd_addr (rd_ptr),
		.rd_data (head_entry)
	);

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ptr <= '0;
		end else if (push) begin
			wr_ptr <= wr_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_ptr <= '0;
		end else if (pop) begin
			rd_ptr <= rd_ptr + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= count + 1'b1;
		end else if (pop && !push) begin
			count <= count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			settle <= 2'h0;
		end else if (pop || (push && count == '0)) begin
			settle <= `HEAD_SETTLE;
		end else if (settle != 2'h0) begin
			settle <= settle - 1'b1;
		end
	end

	assign head_frame_valid = (count != '0) && (settle == 2'h0);

	always_comb begin
		rx_head_status = 16'h0000;
		rx_head_status[`HS_VALID] = head_frame_valid;
		rx_head_status[11:0] = head_frame_valid ? head_entry[23:12] : 12'h000;
	end

	assign rx_head_length = {4'h0, head_frame_valid ? head_entry[11:0] : 12'h000};

	assign rx_frame_counter = count;
endmodule

/* rx_frame_status_tx_queue_cmd_test.sv */
// Self-checking bench for the frame status and transmit command block
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module rx_frame_status_tx_queue_cmd_test;
	logic        clk, reset, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr, araddr, rx_byte_count;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb, send_delay;
	logic [1:0]  bresp, rresp, r;
	logic        rx_frame_done, rx_tcp_bad, rx_udp_bad, rx_symbol_error, rx_runt, rx_crc_error;
	logic        pass_bad_frame, tx_frame_prepared, tx_frame_sent, tx_enqueue, tx_space_event;
	logic [47:0] rx_dest_addr;
	logic [15:0] rx_length_type;
	logic [4:0]  rx_frame_counter;
	logic [12:0] tx_free_bytes;
	int          fail_count, comparisons, enq_n, spc_n;
	localparam logic [11:0] A_ST = 12'h1f0, A_LEN = 12'h1f8, A_CMD = 12'h200;
	localparam logic [11:0] A_SPC = 12'h278, A_REL = 12'h300, A_CNT = 12'h308;
	// Frames: broadcast, unicast with faults, multicast, oversize, runt, crc
	logic [47:0] fd [6] = '{48'hffff_ffff_ffff, 48'h0011_2233_4455, 48'h0100_5e00_0001,
		48'h0011_2233_4455, 48'h0011_2233_4455, 48'h0011_2233_4455};
	logic [15:0] fl [6] = '{16'h0800, 16'h05dc, 16'h05dd, 16'h0800, 16'h0800, 16'h0800};
	logic [11:0] fb [6] = '{12'h040, 12'h03c, 12'h7d0, 12'h7d1, 12'h01e, 12'h040};
	logic [4:0]  ff [6] = '{5'h00, 5'h1c, 5'h00, 5'h00, 5'h02, 5'h01};

	rx_frame_status_tx_queue_cmd dut (.*);
	tx_engine_model eng (.*);

	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		if (tx_enqueue === 1'h1) enq_n++;
		if (tx_space_event === 1'h1) spc_n++;
	end

	function automatic logic [15:0] exp_st(input int i);
		return {1'h1, 3'h0, ff[i][4:3], 2'h0, &fd[i], fd[i][40], ~fd[i][40], ff[i][2],
			fl[i] > 16'h05dc && !ff[i][1], fb[i] > 12'h7d0, ff[i][1:0]};
	endfunction

	task wr(input logic [11:0] a, input logic [31:0] v);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		r = bresp;
	endtask

	task rd(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'h1;
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
	endtask

	task push(input logic [47:0] da, input logic [15:0] lt, input logic [11:0] bc,
		input logic [4:0] f);
		rx_dest_addr <= da;
		rx_length_type <= lt;
		rx_byte_count <= bc;
		{rx_tcp_bad, rx_udp_bad, rx_symbol_error, rx_runt, rx_crc_error} <= f;
		rx_frame_done <= 1'h1;
		@(posedge clk);
		rx_frame_done <= 1'h0;
		@(posedge clk);
	endtask

	task t_idle;
		rd(A_ST); `CHK(d, 32'h0)
		rd(A_CMD); `CHK(d, 32'h0)
		wr(A_ST, 32'hffff); `CHK(r, 2'h0)
		rd(A_LEN); `CHK(d, 32'h0)
		rd(12'h004); `CHK(r, 2'h2)
		wr(12'h004, 32'h1); `CHK(r, 2'h2)
	endtask

	task t_rx;
		pass_bad_frame <= 1'h1;
		for (int i = 0; i < 6; i++) push(fd[i], fl[i], fb[i], ff[i]);
		`CHK(rx_frame_counter, 5'h06)
		rd(A_CNT); `CHK(d, 32'h6)
		for (int i = 0; i < 6; i++) begin
			do rd(A_ST); while (!d[15]);
			`CHK(d, {16'h0, exp_st(i)})
			rd(A_ST); `CHK(d, {16'h0, exp_st(i)})
			rd(A_LEN); `CHK(d, {20'h0, fb[i]})
			wr(A_REL, 32'h1);
		end
		rd(A_ST); `CHK(d, 32'h0)
	endtask

	task t_drop;
		pass_bad_frame <= 1'h0;
		push(fd[1], fl[1], 12'h7d1, 5'h00);
		push(fd[1], fl[1], 12'h040, 5'h02);
		push(fd[1], fl[1], 12'h040, 5'h01);
		`CHK(rx_frame_counter, 5'h00)
		push(fd[1], fl[1], 12'h7d0, 5'h00);
		`CHK(rx_frame_counter, 5'h01)
		wr(A_REL, 32'h1);
		// Seventeen good frames into a sixteen entry queue
		for (int i = 0; i < 17; i++) push(fd[0], fl[0], fb[0], 5'h00);
		`CHK(rx_frame_counter, 5'h10)
	endtask

	task t_tx;
		send_delay <= 4'h8;
		tx_free_bytes <= 13'h0032;
		wr(A_SPC, 32'h64);
		rd(A_SPC); `CHK(d, 32'h64)
		wr(A_CMD, 32'h2);
		repeat (4) @(posedge clk);
		`CHK(spc_n, 0)
		tx_free_bytes <= 13'h0064;
		repeat (3) @(posedge clk);
		`CHK(spc_n, 1)
		rd(A_CMD); `CHK(d, 32'h2)
		wr(A_CMD, 32'h1);
		wr(A_CMD, 32'h1);
		do rd(A_CMD); while (d[0]);
		`CHK(enq_n, 1)
		`CHK(d, 32'h0)
		`CHK(spc_n, 1)
	endtask

	task t_auto;
		send_delay <= 4'h0;
		wr(A_CMD, 32'h4);
		tx_frame_prepared <= 1'h1;
		repeat (2) @(posedge clk);
		tx_frame_prepared <= 1'h0;
		repeat (3) @(posedge clk);
		`CHK(enq_n, 3)
		rd(A_CMD); `CHK(d, 32'h4)
		wr(A_CMD, 32'h0);
		tx_frame_prepared <= 1'h1;
		@(posedge clk);
		tx_frame_prepared <= 1'h0;
		repeat (3) @(posedge clk);
		`CHK(enq_n, 3)
	endtask

	task test_done;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		reset = 1'h1;
		{awvalid, wvalid, arvalid, rx_frame_done, pass_bad_frame, tx_frame_prepared} = 6'h0;
		{rx_tcp_bad, rx_udp_bad, rx_symbol_error, rx_runt, rx_crc_error} = 5'h0;
		{bready, rready, wstrb} = 6'h3f;
		{awaddr, araddr, wdata, rx_byte_count} = 68'h0;
		{rx_dest_addr, rx_length_type, tx_free_bytes, send_delay} = 81'h0;
		repeat (20) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		t_idle;
		t_rx;
		t_drop;
		t_tx;
		t_auto;
		test_done;
	end

	// Cut a hang short
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		test_done;
	end
endmodule

bind rx_frame_status_tx_queue_cmd status_cmd_chk chk (.*);

/* rx_status_mem.sv */
// Storage for the status of received frames waiting in the receive queue
`timescale 1ns/1ps
`include "qmu_cfg.svh"
module rx_status_mem (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                reset,
	// Write port
	input  wire logic                wr_en,
	input  wire logic [`RXQ_AW-1:0]  wr_addr,
	input  wire logic [`ENTRY_W-1:0] wr_data,
	// Read port, data one cycle after the address
	input  wire logic [`RXQ_AW-1:0]  rd_addr,
	output logic      [`ENTRY_W-1:0] rd_data
);
	logic [`ENTRY_W-1:0] store [`RXQ_DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			store[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data <= '0;
		end else begin
			rd_data <= store[rd_addr];
		end
	end
endmodule

/* status_cmd_chk.sv */
// Port checker for the frame status and transmit command block
`timescale 1ns/1ps
module status_cmd_chk (
	// Clock and reset
	input wire logic        clk,
	input wire logic        reset,
	// Register bus
	input wire logic        awready,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic [31:0] rdata,
	// Receive side
	input wire logic        rx_frame_done,
	input wire logic [11:0] rx_byte_count,
	input wire logic        rx_runt,
	input wire logic        rx_crc_error,
	input wire logic        pass_bad_frame,
	input wire logic [4:0]  rx_frame_counter,
	// Transmit side
	input wire logic        tx_frame_prepared,
	input wire logic        tx_enqueue,
	input wire logic        tx_space_event
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	a_b_refuse: assert property (bvalid |-> !awready && !wready)
		else $error("address or data taken while response pending");
	a_r_refuse: assert property (rvalid |-> !arready)
		else $error("read address taken while read data pending");
	a_upper_zero: assert property (rvalid |-> rdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	a_cnt_max: assert property (rx_frame_counter <= 5'h10)
		else $error("frame counter above queue depth");
	a_cnt_step: assert property (rx_frame_counter == $past(rx_frame_counter)
		|| rx_frame_counter == $past(rx_frame_counter) + 5'h1
		|| rx_frame_counter == $past(rx_frame_counter) - 5'h1)
		else $error("frame counter jumped");
	a_bad_drop: assert property (rx_frame_done && !pass_bad_frame
		&& (rx_runt || rx_crc_error || rx_byte_count > 12'h7d0)
		|=> rx_frame_counter <= $past(rx_frame_counter))
		else $error("bad frame kept without pass bad");
	a_good_push: assert property (rx_frame_done && !rx_runt && !rx_crc_error
		&& rx_byte_count <= 12'h7d0 && rx_frame_counter < 5'h10
		|=> rx_frame_counter != 5'h0)
		else $error("good frame not counted");
	a_enq_cause: assert property (tx_enqueue
		|-> $past(tx_frame_prepared) || bvalid || $past(bvalid))
		else $error("enqueue without a cause");
	a_enq_single: assert property (tx_enqueue && !$past(tx_frame_prepared)
		&& !tx_frame_prepared |=> !tx_enqueue)
		else $error("manual enqueue longer than one pulse");
	a_space_once: assert property (tx_space_event |=> !tx_space_event)
		else $error("space event repeated");
endmodule

/* tx_engine_model.sv */
// Transmit engine stand-in: reports a frame sent a delay after the latest enqueue
`timescale 1ns/1ps
module tx_engine_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset,
	// Queue side
	input  wire logic       tx_enqueue,
	input  wire logic [3:0] send_delay,
	output logic            tx_frame_sent
);
	logic       busy;
	logic [3:0] left;

	always_ff @(posedge clk) begin
		if (reset) begin
			busy <= 1'h0;
			left <= 4'h0;
			tx_frame_sent <= 1'h0;
		end else begin
			tx_frame_sent <= 1'h0;
			if (tx_enqueue) begin
				busy <= 1'h1;
				left <= send_delay;
			end else if (busy && left != 4'h0) begin
				left <= left - 4'h1;
			end else if (busy) begin
				busy <= 1'h0;
				tx_frame_sent <= 1'h1;
			end
		end
	end
endmodule

/* tx_queue_ctrl.sv */
// Transmit queue command bits: manual and automatic enqueue, free space watch
`timescale 1ns/1ps
`include "qmu_cfg.svh"
module tx_queue_ctrl (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Command register access
	input  wire logic        cmd_write,
	input  wire logic [2:0]  cmd_data,
	output logic      [2:0]  cmd_state,
	// Transmit engine
	input  wire logic        frame_prepared,
	input  wire logic        frame_sent,
	input  wire logic [12:0] free_bytes,
	input  wire logic [15:0] space_request,
	output logic             enqueue,
	output logic             space_event
);
	logic armed;
	logic manual_go;
	logic auto_go;
	logic space_hit;

	assign manual_go = cmd_write && cmd_data[`TQ_MANUAL] && !cmd_state[`TQ_MANUAL];
	assign auto_go   = cmd_state[`TQ_AUTO] && frame_prepared;
	assign space_hit = armed && ({3'h0, free_bytes} >= space_request);

	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_state <= `TQ_CMD_RESET;
		end else begin
			cmd_state[`TQ_MANUAL] <= manual_go || (cmd_state[`TQ_MANUAL] && !frame_sent);
			cmd_state[`TQ_WATCH] <= (cmd_write && cmd_data[`TQ_WATCH])
				|| (cmd_state[`TQ_WATCH] && !frame_sent);
			if (cmd_write) begin
				cmd_state[`TQ_AUTO] <= cmd_data[`TQ_AUTO];
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			armed <= 1'b0;
		end else if (cmd_write && cmd_data[`TQ_WATCH]) begin
			armed <= 1'b1;
		end else if (space_hit) begin
			armed <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			enqueue     <= 1'b0;
			space_event <= 1'b0;
		end else begin
			enqueue     <= manual_go || auto_go;
			space_event <= space_hit;
		end
	end
endmodule
